/* File: rtl/event_router_defs.vh */
// constants for the peripheral event router
`ifndef EVENT_ROUTER_DEFS_VH
`define EVENT_ROUTER_DEFS_VH
// wishbone register byte offsets
`define ER_REG_SRC_EN 8'h00
`define ER_REG_USR_EN 8'h04
`define ER_REG_CMP_CFG 8'h08
`define ER_REG_ADC_CFG 8'h0c
`define ER_REG_STATUS 8'h10
`define ER_REG_COUNT 8'h14
// source enable fields
`define ER_SRC_CMP_UP 0
`define ER_SRC_CMP_DN 1
`define ER_SRC_PIN_A 2
`define ER_SRC_PIN_B 3
`define ER_SRC_ATMR 4
`define ER_SRC_PWM0 5
// user enable fields
`define ER_USR_PWM 0
`define ER_USR_TMR1 1
`define ER_USR_TMR2 2
`define ER_USR_CMP 3
`define ER_USR_ADC 4
`define ER_USR_TOUCH 5
// comparator config: 8 two-bit fields in [15:0], event enable at bit 16
`define ER_CMP_EVEN_BIT 16
`define ER_CMP_MODE_EVENT 2'h3
// adc trigger mode in [2:0]
`define ER_ADC_TRIG_EVENT 3'h7
// reset values
`define ER_SRC_EN_RESET 6'h00
`define ER_USR_EN_RESET 6'h00
`define ER_CMP_CFG_RESET 17'h00000
`define ER_ADC_CFG_RESET 3'h0
`endif

/* File: rtl/event_sync.v */
// two-flop level synchroniser with edge pulse output
`timescale 1ns/1ns
module event_sync (
  input wire clk_in,
  input wire nrst_in,
  input wire [2:0] level_in,
  output reg [2:0] pulse_out
);
  reg [2:0] meta;
  reg [2:0] stable;
  reg [2:0] prev;
  // meta feeds only stable; edge taken on the stable copy
  always @(posedge clk_in) begin
    if (!nrst_in) begin
      meta <= 3'h0;
      stable <= 3'h0;
      prev <= 3'h0;
      pulse_out <= 3'h0;
    end else begin
      meta <= level_in;
      stable <= meta;
      prev <= stable;
      pulse_out <= stable & ~prev;
    end
  end
endmodule // event_sync

/* File: rtl/peripheral_event_router.v */
// fixed peripheral event routing network with wishbone enables
//
// Local design decisions: the register addresses and the Wishbone register port.
`timescale 1ns/1ns
`include "event_router_defs.vh"

module peripheral_event_router (
  input wire clk_in,
  input wire nrst_in,
  // wishbone classic slave
  input wire wb_cyc_in,
  input wire wb_stb_in,
  input wire wb_we_in,
  input wire [7:0] wb_adr_in,
  input wire [3:0] wb_sel_in,
  input wire [31:0] wb_dat_in,
  output reg [31:0] wb_dat_out,
  output reg wb_ack_out,
  output reg wb_err_out,
  // generators
  input wire [7:0] cmp_up_in,
  input wire [7:0] cmp_dn_in,
  input wire [23:0] port_a_change_in,
  input wire [15:0] port_b_change_in,
  input wire [2:0] atmr_level_in,
  input wire pwm0_match_in,
  // users
  output reg [20:0] pwm_inc_out,
  output reg [20:0] pwm_dec_out,
  output reg touch_matrix_out,
  output reg touch_iter_out,
  output reg [2:0] tmr_first_capture_out,
  output reg [2:0] tmr_second_capture_out,
  output reg [7:0] cmp_start_out,
  output reg adc_start_out,
  output reg [5:0] clk_request_out
);

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  reg [5:0] src_en;
  reg [5:0] usr_en;
  reg [16:0] cmp_cfg;
  reg [2:0] adc_cfg;
  reg [15:0] event_count;
  reg [5:0] seen;
  wire [2:0] atmr_pulse;

  // byte-lane merge for writes
  function [31:0] lane_merge;
    input [31:0] old;
    input [31:0] val;
    input [3:0] sel;
    integer i;
    begin
      for (i = 0; i < 4; i = i + 1) begin
        lane_merge[i*8 +: 8] = sel[i] ? val[i*8 +: 8] : old[i*8 +: 8];
      end
    end
  endfunction

  // per-group OR reduce of a pin change bus into 8-pin groups
  function group_or;
    input [7:0] pins;
    begin
      group_or = |pins;
    end
  endfunction

  // event trigger mode of the adc, decoded for start and clock request
  function adc_event_sel;
    input [2:0] mode;
    begin
      adc_event_sel = (mode == `ER_ADC_TRIG_EVENT);
    end
  endfunction

  // true for every offset that has a register behind it
  function adr_mapped;
    input [7:0] adr;
    begin
      case (adr)
        `ER_REG_SRC_EN, `ER_REG_USR_EN, `ER_REG_CMP_CFG: adr_mapped = 1'b1;
        `ER_REG_ADC_CFG, `ER_REG_STATUS, `ER_REG_COUNT: adr_mapped = 1'b1;
        default: adr_mapped = 1'b0;
      endcase
    end
  endfunction

  // ------------------------------------------------------------
  // async timer synchronisation
  // ------------------------------------------------------------
  // the timer side may run while this clock is stopped; its edges arrive
  // four edges late: two to settle, one to find the edge, one to register
  // synchronise timer events
  event_sync u_atmr_sync (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .level_in(atmr_level_in),
    .pulse_out(atmr_pulse)
  );

  // ------------------------------------------------------------
  // routing logic
  // ------------------------------------------------------------
  reg [20:0] next_inc;
  reg [20:0] next_dec;
  reg [7:0] next_cmp_start;
  reg [2:0] next_cap1;
  reg [2:0] next_cap2;
  reg next_touch_m;
  reg next_touch_i;
  reg next_adc;
  reg [5:0] next_clk_req;
  reg [7:0] up_g;
  reg [7:0] dn_g;
  reg any_trig;
  reg atmr_any;
  integer k;

  always @* begin
    up_g = src_en[`ER_SRC_CMP_UP] ? cmp_up_in : 8'h00;
    dn_g = src_en[`ER_SRC_CMP_DN] ? cmp_dn_in : 8'h00;
    // channels without a comparator partner stay at zero
    next_inc = 21'h0;
    next_dec = 21'h0;
    if (usr_en[`ER_USR_PWM]) begin
      next_inc[0] = up_g[0];
      next_inc[6] = up_g[1];
      next_inc[8] = up_g[2];
      next_inc[9] = up_g[3];
      next_inc[11] = up_g[4];
      next_inc[14] = up_g[5];
      next_inc[19] = up_g[6];
      next_inc[20] = up_g[7];
      next_dec[0] = dn_g[0];
      next_dec[6] = dn_g[1];
      next_dec[8] = dn_g[2];
      next_dec[9] = dn_g[3];
      next_dec[11] = dn_g[4];
      next_dec[14] = dn_g[5];
      next_dec[19] = dn_g[6];
      next_dec[20] = dn_g[7];
    end
    next_touch_m = usr_en[`ER_USR_TOUCH] & (|dn_g);
    atmr_any = src_en[`ER_SRC_ATMR] & (|atmr_pulse);
    next_touch_i = usr_en[`ER_USR_TOUCH] & atmr_any;
    any_trig = atmr_any | (src_en[`ER_SRC_PWM0] & pwm0_match_in);
    for (k = 0; k < 8; k = k + 1) begin
      next_cmp_start[k] = any_trig & usr_en[`ER_USR_CMP] & cmp_cfg[`ER_CMP_EVEN_BIT]
        & (cmp_cfg[k*2 +: 2] == `ER_CMP_MODE_EVENT);
    end
    next_adc = any_trig & usr_en[`ER_USR_ADC] & adc_event_sel(adc_cfg);
    next_clk_req = 6'h00;
    next_clk_req[5] = usr_en[`ER_USR_TOUCH] & atmr_any;
    next_clk_req[4] = usr_en[`ER_USR_ADC] & atmr_any & adc_event_sel(adc_cfg);
    next_clk_req[3] = usr_en[`ER_USR_CMP] & atmr_any & cmp_cfg[`ER_CMP_EVEN_BIT];
    next_cap1[0] = group_or(port_a_change_in[7:0]);
    next_cap1[1] = group_or(port_a_change_in[15:8]);
    next_cap1[2] = group_or(port_a_change_in[23:16]);
    if (!(src_en[`ER_SRC_PIN_A] & usr_en[`ER_USR_TMR1])) begin
      next_cap1 = 3'h0;
    end
    // port B groups, channel 0 unused
    next_cap2[0] = 1'b0;
    next_cap2[1] = group_or(port_b_change_in[7:0]);
    next_cap2[2] = group_or(port_b_change_in[15:8]);
    if (!(src_en[`ER_SRC_PIN_B] & usr_en[`ER_USR_TMR2])) begin
      next_cap2 = 3'h0;
    end
  end

  // ------------------------------------------------------------
  // output stage
  // ------------------------------------------------------------
  // every user sees its event one edge after the source, except timer events, which arrive four edges late
  // one register stage for every path
  always @(posedge clk_in) begin
    if (!nrst_in) begin
      pwm_inc_out <= 21'h0;
      pwm_dec_out <= 21'h0;
      touch_matrix_out <= 1'b0;
      touch_iter_out <= 1'b0;
      tmr_first_capture_out <= 3'h0;
      tmr_second_capture_out <= 3'h0;
      cmp_start_out <= 8'h00;
      adc_start_out <= 1'b0;
      clk_request_out <= 6'h00;
    end else begin
      pwm_inc_out <= next_inc;
      pwm_dec_out <= next_dec;
      touch_matrix_out <= next_touch_m;
      touch_iter_out <= next_touch_i;
      tmr_first_capture_out <= next_cap1;
      tmr_second_capture_out <= next_cap2;
      cmp_start_out <= next_cmp_start;
      adc_start_out <= next_adc;
      clk_request_out <= next_clk_req;
    end
  end

  // ------------------------------------------------------------
  // status: sticky seen flags and event counter
  // ------------------------------------------------------------
  // comparator hits gated by their source enables only, not by user enables
  // sync events need only their source enable and the clock
  // a pin port counts once per cycle however many pins or groups changed
  wire [5:0] hits = {src_en[`ER_SRC_PWM0] & pwm0_match_in, atmr_any,
                     |(port_b_change_in) & src_en[`ER_SRC_PIN_B],
                     |(port_a_change_in) & src_en[`ER_SRC_PIN_A], |dn_g, |up_g};
  wire wb_req = wb_cyc_in & wb_stb_in & ~wb_ack_out & ~wb_err_out;
  wire wb_wr = wb_req & wb_we_in;
  wire adr_ok = adr_mapped(wb_adr_in);
  wire [31:0] st_merge = lane_merge(32'h0, wb_dat_in, wb_sel_in);
  // merged write words, cut to each register's width on purpose
  wire [31:0] src_wr = lane_merge({26'h0, src_en}, wb_dat_in, wb_sel_in);
  wire [31:0] usr_wr = lane_merge({26'h0, usr_en}, wb_dat_in, wb_sel_in);
  wire [31:0] cmp_wr = lane_merge({15'h0, cmp_cfg}, wb_dat_in, wb_sel_in);
  wire [31:0] adc_wr = lane_merge({29'h0, adc_cfg}, wb_dat_in, wb_sel_in);

  // ------------------------------------------------------------
  // wishbone slave
  // ------------------------------------------------------------
  // one-cycle ack, err for unmapped offsets
  // a held request is not taken again while its ack or err stands
  always @(posedge clk_in) begin
    if (!nrst_in) begin
      src_en <= `ER_SRC_EN_RESET;
      usr_en <= `ER_USR_EN_RESET;
      cmp_cfg <= `ER_CMP_CFG_RESET;
      adc_cfg <= `ER_ADC_CFG_RESET;
      seen <= 6'h00;
      event_count <= 16'h0000;
      wb_ack_out <= 1'b0;
      wb_err_out <= 1'b0;
      wb_dat_out <= 32'h00000000;
    end else begin
      wb_ack_out <= wb_req & adr_ok;
      wb_err_out <= wb_req & ~adr_ok;
      // counter wraps; software reads differences
      if (hits != 6'h00) begin
        event_count <= event_count + 16'h0001;
      end
      // set wins over write-one-to-clear
      if (wb_wr && wb_adr_in == `ER_REG_STATUS) begin
        seen <= (seen & ~st_merge[5:0]) | hits;
      end else begin
        seen <= seen | hits;
      end
      if (wb_wr) begin
        case (wb_adr_in)
          `ER_REG_SRC_EN: src_en <= src_wr[5:0];
          `ER_REG_USR_EN: usr_en <= usr_wr[5:0];
          `ER_REG_CMP_CFG: cmp_cfg <= cmp_wr[16:0];
          `ER_REG_ADC_CFG: adc_cfg <= adc_wr[2:0];
          default: ;
        endcase
      end
      case (wb_adr_in)
        `ER_REG_SRC_EN: wb_dat_out <= {26'h0, src_en};
        `ER_REG_USR_EN: wb_dat_out <= {26'h0, usr_en};
        `ER_REG_CMP_CFG: wb_dat_out <= {15'h0, cmp_cfg};
        `ER_REG_ADC_CFG: wb_dat_out <= {29'h0, adc_cfg};
        `ER_REG_STATUS: wb_dat_out <= {26'h0, seen};
        `ER_REG_COUNT: wb_dat_out <= {16'h0, event_count};
        default: wb_dat_out <= 32'h00000000;
      endcase
    end
  end

endmodule // peripheral_event_router

/* File: verification/event_router_chk.sv */
// port-level assertion checker for the event router
`timescale 1ns/1ns
module event_router_chk (
  input wire clk_in,
  input wire nrst_in,
  input wire wb_cyc_in,
  input wire wb_stb_in,
  input wire wb_ack_out,
  input wire wb_err_out,
  input wire [7:0] cmp_up_in,
  input wire [7:0] cmp_dn_in,
  input wire [23:0] port_a_change_in,
  input wire [15:0] port_b_change_in,
  input wire [2:0] atmr_level_in,
  input wire pwm0_match_in,
  input wire [20:0] pwm_inc_out,
  input wire [20:0] pwm_dec_out,
  input wire touch_matrix_out,
  input wire touch_iter_out,
  input wire [2:0] tmr_first_capture_out,
  input wire [2:0] tmr_second_capture_out,
  input wire [7:0] cmp_start_out,
  input wire adc_start_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  // -------------------------------------------
  // bus and event relations
  // -------------------------------------------
  sequence s_req;
    wb_cyc_in && wb_stb_in && !wb_ack_out && !wb_err_out;
  endsequence
  sequence s_ans;
    (wb_ack_out || wb_err_out) ##1 !(wb_ack_out || wb_err_out);
  endsequence
  AST_BUS: assert property (s_req |=> s_ans)
    else $error("bus answer missing");
  AST_INC: assert property (pwm_inc_out[6] |-> $past(cmp_up_in[1]))
    else $error("inc without cause");
  AST_DEC: assert property (pwm_dec_out[20] |-> $past(cmp_dn_in[7]))
    else $error("dec without cause");
  AST_UNUSED: assert property (((pwm_inc_out | pwm_dec_out) & ~21'h184b41) == 21'h0)
    else $error("unpaired pwm pulse");
  AST_TOUCH: assert property (touch_matrix_out |-> $past(|cmp_dn_in))
    else $error("touch without cause");
  AST_CAPA: assert property (tmr_first_capture_out[1] |-> $past(|port_a_change_in[15:8]))
    else $error("capture a wrong");
  AST_CAPB: assert property (tmr_second_capture_out[2] |-> $past(|port_b_change_in[15:8]))
    else $error("capture b wrong");
  AST_ITER: assert property (touch_iter_out |->
    $past(|atmr_level_in, 2) ##1 !touch_iter_out)
    else $error("iteration pulse wrong");
  AST_CMP: assert property (cmp_start_out != 8'h00 |->
    $past(pwm0_match_in) || $past(|atmr_level_in, 2))
    else $error("compare start without cause");
  AST_ADC: assert property (adc_start_out |->
    $past(pwm0_match_in) || $past(|atmr_level_in, 2))
    else $error("adc start without cause");
endmodule // event_router_chk
bind peripheral_event_router event_router_chk u_event_router_chk (.*);

/* File: verification/event_peripherals_model.sv */
// timer generator and touch user model on the far side
`timescale 1ns/1ns
module event_peripherals_model (
  input wire clk_in,
  input wire nrst_in,
  input wire [2:0] fire_in,
  input wire iter_in,
  output logic [2:0] atmr_level_out,
  output int iters_out
);
  int hold;
  always @(posedge clk_in) begin
    if (!nrst_in) begin
      atmr_level_out <= 3'h0;
      hold <= 0;
    end else if (fire_in != 3'h0) begin
      atmr_level_out <= fire_in;
      hold <= 4;
    end else if (hold > 0) begin
      hold <= hold - 1;
    end else begin
      atmr_level_out <= 3'h0;
    end
  end
  always @(posedge clk_in) begin
    if (!nrst_in) begin
      iters_out <= 0;
    end else if (iter_in) begin
      iters_out <= iters_out + 1;
    end
  end
endmodule // event_peripherals_model

/* File: verification/testbench.sv */
// self-checking bench for the event router
`timescale 1ns/1ns
`include "event_router_defs.vh"
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin fails++; \
  $display("unexpected %s exp %h got %h", nm, e, g); end end
module testbench;
  logic clk_in = 0, nrst_in = 0, wb_cyc_in = 0, wb_stb_in = 0, wb_we_in = 0;
  logic pwm0_match_in = 0, wb_ack_out, wb_err_out, err;
  logic touch_matrix_out, touch_iter_out, adc_start_out;
  logic [7:0] wb_adr_in = 0, cmp_up_in = 0, cmp_dn_in = 0, cmp_start_out;
  logic [3:0] wb_sel_in = 4'hf;
  logic [31:0] wb_dat_in = 0, wb_dat_out, q;
  logic [23:0] port_a_change_in = 0;
  logic [15:0] port_b_change_in = 0;
  logic [2:0] atmr_level_in, fire = 0, tmr_first_capture_out, tmr_second_capture_out;
  logic [20:0] pwm_inc_out, pwm_dec_out;
  logic [5:0] clk_request_out;
  int fails = 0, n_tests = 0, cyc_n = 0, iters;
  int pr[8] = '{0, 6, 8, 9, 11, 14, 19, 20};
  peripheral_event_router u_peripheral_event_router (.*);
  event_peripherals_model u_event_peripherals_model (.clk_in(clk_in), .nrst_in(nrst_in),
    .fire_in(fire), .iter_in(touch_iter_out),
    .atmr_level_out(atmr_level_in), .iters_out(iters));
  initial forever #10 clk_in = ~clk_in;
  // hang guard
  always @(posedge clk_in) begin
    cyc_n++;
    if (cyc_n == 20000) begin
      fails++;
      test_done;
    end
  end
  task test_done;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // classic single wishbone cycle, held until ack or err is sampled high
  task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    {wb_cyc_in, wb_stb_in, wb_we_in, wb_adr_in, wb_dat_in} <= {2'b11, we, a, d};
    // the hang guard ends a wait for an answer that never comes
    do begin
      @(posedge clk_in);
    end while (!wb_ack_out && !wb_err_out);
    q = wb_dat_out;
    err = wb_err_out;
    {wb_cyc_in, wb_stb_in} <= 2'b00;
  endtask
  // clear sync inputs on the taking edge, then look once the answer settles
  task fire_ev;
    @(posedge clk_in);
    {cmp_up_in, cmp_dn_in, port_a_change_in, port_b_change_in, pwm0_match_in} <= '0;
    #1;
  endtask
  task t_regs;
    for (int i = 0; i < 6; i++) begin
      wb(0, 8'(i * 4), 0);
      `CHK("reset value", 32'h0, q)
    end
    wb(1, 8'h20, 32'h5);
    `CHK("unmapped err", 1'b1, err)
    wb(1, `ER_REG_SRC_EN, 32'h3f);
    wb(0, `ER_REG_SRC_EN, 0);
    `CHK("source enable", 32'h3f, q)
  endtask
  task t_cmp;
    @(posedge clk_in);
    cmp_up_in <= 8'h02;
    fire_ev;
    `CHK("gated inc", 21'h0, pwm_inc_out)
    wb(1, `ER_REG_USR_EN, 32'h3f);
    for (int k = 0; k < 8; k++) begin
      @(posedge clk_in);
      cmp_up_in <= 8'(1 << k);
      fire_ev;
      `CHK("inc", 21'(1 << pr[k]), pwm_inc_out)
      @(posedge clk_in);
      cmp_dn_in <= 8'(1 << k);
      fire_ev;
      `CHK("dec", 21'(1 << pr[k]), pwm_dec_out)
      `CHK("touch matrix", 1'b1, touch_matrix_out)
    end
    @(posedge clk_in);
    #1;
    `CHK("touch pulse end", 1'b0, touch_matrix_out)
  endtask
  task t_pin;
    for (int g = 0; g < 3; g++) begin
      @(posedge clk_in);
      port_a_change_in <= 24'h81 << (8 * g);
      fire_ev;
      `CHK("capture first", 3'(1 << g), tmr_first_capture_out)
    end
    for (int g = 0; g < 2; g++) begin
      @(posedge clk_in);
      port_b_change_in <= 16'h18 << (8 * g);
      fire_ev;
      `CHK("capture second", 3'(2 << g), tmr_second_capture_out)
    end
  endtask
  task t_timer;
    wb(1, `ER_REG_CMP_CFG, 32'h00010030);
    wb(1, `ER_REG_ADC_CFG, 32'h7);
    for (int i = 0; i < 3; i++) begin
      @(posedge clk_in);
      fire <= 3'(1 << i);
      @(posedge clk_in);
      fire <= 3'h0;
      // level rises at this edge; users see it four edges later
      repeat (4) @(posedge clk_in);
      #1;
      `CHK("touch iteration", 1'b1, touch_iter_out)
      `CHK("cmp start", 8'h04, cmp_start_out)
      `CHK("adc start", 1'b1, adc_start_out)
      `CHK("clock request", 6'h38, clk_request_out)
      @(posedge clk_in);
      #1;
      `CHK("iteration pulse end", 1'b0, touch_iter_out)
      repeat (6) @(posedge clk_in);
    end
    `CHK("iterations", 3, iters)
    @(posedge clk_in);
    pwm0_match_in <= 1'b1;
    fire_ev;
    `CHK("pwm0 cmp", 8'h04, cmp_start_out)
    `CHK("pwm0 adc", 1'b1, adc_start_out)
    `CHK("no clock request", 6'h00, clk_request_out)
    wb(1, `ER_REG_ADC_CFG, 32'h6);
    @(posedge clk_in);
    pwm0_match_in <= 1'b1;
    fire_ev;
    `CHK("adc gated", 1'b0, adc_start_out)
    wb(0, `ER_REG_STATUS, 0);
    `CHK("seen flags", 32'h3f, q)
    wb(0, `ER_REG_COUNT, 0);
    `CHK("event count", 32'h1b, q)
    wb(1, `ER_REG_STATUS, 32'h3f);
    wb(0, `ER_REG_STATUS, 0);
    `CHK("seen cleared", 32'h0, q)
  endtask
  initial begin
    repeat (8) @(posedge clk_in);
    nrst_in <= 1'b1;
    t_regs;
    t_cmp;
    t_pin;
    t_timer;
    test_done;
  end
endmodule // testbench
